// ===== hw/acc_pkg.sv
/*
 * constants of the audio converter control block: port register, converter
 * register offsets, field positions, reset values and serial frame sizes.
 * assumes the 8-bit special function register bus of the host core.
 */
package acc_pkg;
    // port register on the host core's special function bus
    localparam logic [7:0] AUX_ADDR = 8'h90;
    localparam logic [7:0] AUX_RESET = 8'hff;
    localparam int unsigned AUX_SEL_BIT = 1;
    localparam int unsigned AUX_CLK_BIT = 2;
    localparam int unsigned AUX_DIN_BIT = 3;
    localparam int unsigned AUX_DOUT_BIT = 4;

    // converter register offsets, reached through the serial link
    localparam int unsigned OFS_W = 7;
    localparam logic [6:0] OFS_POWER = 7'h00;
    localparam logic [6:0] OFS_LEFT_IN = 7'h01;
    localparam logic [6:0] OFS_RIGHT_IN = 7'h02;
    localparam logic [6:0] OFS_LEFT_PLAY = 7'h03;
    localparam logic [6:0] OFS_RIGHT_PLAY = 7'h04;

    // power enable bit positions
    localparam int unsigned PWR_LEFT_IN = 0;
    localparam int unsigned PWR_RIGHT_IN = 1;
    localparam int unsigned PWR_LEFT_OUT = 2;
    localparam int unsigned PWR_RIGHT_OUT = 3;
    localparam int unsigned PWR_LEFT_CH = 4;
    localparam int unsigned PWR_RIGHT_CH = 5;
    localparam int unsigned PWR_AUX = 6;
    localparam int unsigned PWR_MONO = 7;

    // gain fields and reset values
    localparam int unsigned IN_GAIN_W = 5;
    localparam int unsigned PLAY_GAIN_W = 6;
    localparam logic [7:0] POWER_RESET = 8'h00;
    localparam logic [4:0] IN_GAIN_RESET = 5'h05;
    localparam logic [5:0] PLAY_GAIN_RESET = 6'h08;
    localparam logic [4:0] IN_GAIN_OFF = 5'h11;
    localparam logic [5:0] PLAY_GAIN_MUTE = 6'h20;

    // serial frame: read flag and offset, then one data byte, msb first
    localparam int unsigned CMD_BITS = 8;
    localparam int unsigned FRAME_BITS = 16;
    localparam logic [4:0] CNT_CMD = 5'd8;
    localparam logic [4:0] CNT_FRAME = 5'd16;
endpackage : acc_pkg

// ===== hw/acc_link_if.sv
/*
 * carrier between the port register and the converter's serial slave.
 * assumes one clock domain; pin levels come from port register flops.
 */
`timescale 1ns/1ps
interface acc_link_if;
    logic selectN;
    logic serialClock;
    logic serialIn;
    logic serialOut;
    logic wrStb;
    logic [6:0] wrAddr;
    logic [7:0] wrData;
    logic [6:0] rdAddr;
    logic [7:0] rdData;

    modport regs (output selectN, output serialClock, output serialIn, input serialOut,
        input wrStb, input wrAddr, input wrData, input rdAddr, output rdData);
    modport slave (input selectN, input serialClock, input serialIn, output serialOut,
        output wrStb, output wrAddr, output wrData, output rdAddr, input rdData);
endinterface : acc_link_if

// ===== hw/acc_serial_slave.sv
/*
 * serial slave of the converter: shifts a command byte and a data byte in on
 * rising serial clock edges while select is low, and shifts read data out.
 * assumes select, clock and data in come from flops in the same clock domain.
 */
`timescale 1ns/1ps
module acc_serial_slave (
    input wire logic ref_clk,
    input wire logic srst,
    acc_link_if.slave link
);
    logic prevClk;
    logic [4:0] bitCnt;
    logic [14:0] shIn;
    logic [7:0] cmd;
    logic [7:0] shOut;
    logic loadPend;
    logic serialOut;
    logic wrStb;
    logic [6:0] wrAddr;
    logic [7:0] wrData;
    logic next_prevClk;
    logic [4:0] next_bitCnt;
    logic [14:0] next_shIn;
    logic [7:0] next_cmd;
    logic [7:0] next_shOut;
    logic next_loadPend;
    logic next_serialOut;
    logic next_wrStb;
    logic [6:0] next_wrAddr;
    logic [7:0] next_wrData;
    logic rise;

    assign rise = link.serialClock && !prevClk;
    assign link.serialOut = serialOut;
    assign link.wrStb = wrStb;
    assign link.wrAddr = wrAddr;
    assign link.wrData = wrData;
    assign link.rdAddr = cmd[6:0];

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_prevClk = link.serialClock;
        next_bitCnt = bitCnt;
        next_shIn = shIn;
        next_cmd = cmd;
        next_shOut = shOut;
        next_loadPend = 1'b0;
        next_serialOut = serialOut;
        next_wrStb = 1'b0;
        next_wrAddr = wrAddr;
        next_wrData = wrData;
        if (link.selectN)
        begin
            // deselected: frame dropped, data out idles high
            next_bitCnt = '0;
            next_serialOut = 1'b1;
        end
        else if (loadPend)
        begin
            // read data is fetched one cycle after the offset is known
            next_serialOut = link.rdData[7];
            next_shOut = {link.rdData[6:0], 1'b0};
        end
        else if (rise && bitCnt < acc_pkg::CNT_FRAME)
        begin
            // bits are taken on the rising clock edge, msb first
            next_shIn = {shIn[13:0], link.serialIn};
            next_bitCnt = bitCnt + 5'd1;
            if (bitCnt == acc_pkg::CNT_CMD - 5'd1)
            begin
                next_cmd = {shIn[6:0], link.serialIn};
                next_loadPend = shIn[6];
            end
            if (bitCnt >= acc_pkg::CNT_CMD)
            begin
                next_serialOut = shOut[7];
                next_shOut = {shOut[6:0], 1'b0};
            end
            if (bitCnt == acc_pkg::CNT_FRAME - 5'd1 && !cmd[7])
            begin
                next_wrStb = 1'b1;
                next_wrAddr = cmd[6:0];
                next_wrData = {shIn[6:0], link.serialIn};
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            prevClk <= 1'b1;
            bitCnt <= '0;
            shIn <= '0;
            cmd <= '0;
            shOut <= '0;
            loadPend <= 1'b0;
            serialOut <= 1'b1;
            wrStb <= 1'b0;
            wrAddr <= '0;
            wrData <= '0;
        end
        else
        begin
            prevClk <= next_prevClk;
            bitCnt <= next_bitCnt;
            shIn <= next_shIn;
            cmd <= next_cmd;
            shOut <= next_shOut;
            loadPend <= next_loadPend;
            serialOut <= next_serialOut;
            wrStb <= next_wrStb;
            wrAddr <= next_wrAddr;
            wrData <= next_wrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_deselect_drops_frame: assert property (link.selectN |=> bitCnt == 5'd0 && !wrStb)
        else $error("frame not dropped while deselected");
    a_write_needs_frame: assert property (wrStb |-> $past(bitCnt) == acc_pkg::CNT_FRAME - 5'd1)
        else $error("write strobe without a full frame");
endmodule : acc_serial_slave

// ===== hw/acc_ctrl_regs.sv
/*
 * audio converter control: port register on the special function bus whose
 * bits drive the converter's serial link, and the converter's power and gain
 * registers written and read over that link.
 * assumes the host core presents sfr address, strobes and data synchronous
 * to ref_clk, and software toggles the link bits slowly.
 */
`timescale 1ns/1ps
module acc_ctrl_regs (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWr,
    input wire logic sfrRd,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    output logic [7:0] auxiliaryPortPins,
    output logic converterSerialOut,
    output logic monoAmpPowerOn,
    output logic auxAmpPowerOn,
    output logic rightChannelPowerOn,
    output logic leftChannelPowerOn,
    output logic rightOutDriverPowerOn,
    output logic leftOutDriverPowerOn,
    output logic rightInAmpPowerOn,
    output logic leftInAmpPowerOn,
    output logic [4:0] leftInputGainCode,
    output logic [4:0] rightInputGainCode,
    output logic [5:0] leftPlaybackGainCode,
    output logic [5:0] rightPlaybackGainCode,
    output logic leftInputCutOff,
    output logic rightInputCutOff,
    output logic leftPlaybackMute,
    output logic rightPlaybackMute
);
    acc_link_if link ();

    logic [7:0] auxPort;
    logic [7:0] powerEn;
    logic [4:0] leftIn;
    logic [4:0] rightIn;
    logic [5:0] leftPlay;
    logic [5:0] rightPlay;
    logic [7:0] rdata;
    logic leftCut;
    logic rightCut;
    logic leftMute;
    logic rightMute;
    logic [7:0] next_auxPort;
    logic [7:0] next_powerEn;
    logic [4:0] next_leftIn;
    logic [4:0] next_rightIn;
    logic [5:0] next_leftPlay;
    logic [5:0] next_rightPlay;
    logic [7:0] next_rdata;
    logic next_leftCut;
    logic next_rightCut;
    logic next_leftMute;
    logic next_rightMute;
    logic auxHit;

    ////////////////////////////////////////////////////////////////////////
    // serial slave of the converter
    acc_serial_slave u_slave (
        .ref_clk(ref_clk),
        .srst(srst),
        .link(link.slave)
    );

    // link lines come straight from port register flops
    assign link.selectN = auxPort[acc_pkg::AUX_SEL_BIT];
    assign link.serialClock = auxPort[acc_pkg::AUX_CLK_BIT];
    assign link.serialIn = auxPort[acc_pkg::AUX_DIN_BIT];

    // read data for the link; unused upper bits read as zero
    always_comb
    begin
        case (link.rdAddr)
            acc_pkg::OFS_POWER: link.rdData = powerEn;
            acc_pkg::OFS_LEFT_IN: link.rdData = {3'h0, leftIn};
            acc_pkg::OFS_RIGHT_IN: link.rdData = {3'h0, rightIn};
            acc_pkg::OFS_LEFT_PLAY: link.rdData = {2'h0, leftPlay};
            acc_pkg::OFS_RIGHT_PLAY: link.rdData = {2'h0, rightPlay};
            default: link.rdData = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // port register on the special function bus
    assign auxHit = sfrAddr == acc_pkg::AUX_ADDR;

    always_comb
    begin
        next_auxPort = auxPort;
        next_rdata = 8'h00;
        if (sfrWr && auxHit)
        begin
            // data out bit follows the converter, a write there is ignored
            next_auxPort = sfrWdata;
            next_auxPort[acc_pkg::AUX_DOUT_BIT] = 1'b1;
        end
        if (sfrRd && auxHit)
        begin
            next_rdata = auxPort;
            next_rdata[acc_pkg::AUX_DOUT_BIT] = link.serialOut;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            auxPort <= acc_pkg::AUX_RESET;
            rdata <= 8'h00;
        end
        else
        begin
            auxPort <= next_auxPort;
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // converter registers, written by a completed link frame
    always_comb
    begin
        next_powerEn = powerEn;
        next_leftIn = leftIn;
        next_rightIn = rightIn;
        next_leftPlay = leftPlay;
        next_rightPlay = rightPlay;
        if (link.wrStb)
        begin
            case (link.wrAddr)
                acc_pkg::OFS_POWER: next_powerEn = link.wrData;
                acc_pkg::OFS_LEFT_IN: next_leftIn = link.wrData[4:0];
                acc_pkg::OFS_RIGHT_IN: next_rightIn = link.wrData[4:0];
                acc_pkg::OFS_LEFT_PLAY: next_leftPlay = link.wrData[5:0];
                acc_pkg::OFS_RIGHT_PLAY: next_rightPlay = link.wrData[5:0];
                default: next_powerEn = powerEn;
            endcase
        end
        // decoded from the next value so the flags track the codes exactly
        next_leftCut = next_leftIn == acc_pkg::IN_GAIN_OFF;
        next_rightCut = next_rightIn == acc_pkg::IN_GAIN_OFF;
        next_leftMute = next_leftPlay == acc_pkg::PLAY_GAIN_MUTE;
        next_rightMute = next_rightPlay == acc_pkg::PLAY_GAIN_MUTE;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            powerEn <= acc_pkg::POWER_RESET;
            leftIn <= acc_pkg::IN_GAIN_RESET;
            rightIn <= acc_pkg::IN_GAIN_RESET;
            leftPlay <= acc_pkg::PLAY_GAIN_RESET;
            rightPlay <= acc_pkg::PLAY_GAIN_RESET;
            leftCut <= 1'b0;
            rightCut <= 1'b0;
            leftMute <= 1'b0;
            rightMute <= 1'b0;
        end
        else
        begin
            powerEn <= next_powerEn;
            leftIn <= next_leftIn;
            rightIn <= next_rightIn;
            leftPlay <= next_leftPlay;
            rightPlay <= next_rightPlay;
            leftCut <= next_leftCut;
            rightCut <= next_rightCut;
            leftMute <= next_leftMute;
            rightMute <= next_rightMute;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flop
    assign sfrRdata = rdata;
    assign auxiliaryPortPins = auxPort;
    assign converterSerialOut = link.serialOut;
    assign monoAmpPowerOn = powerEn[acc_pkg::PWR_MONO];
    assign auxAmpPowerOn = powerEn[acc_pkg::PWR_AUX];
    assign rightChannelPowerOn = powerEn[acc_pkg::PWR_RIGHT_CH];
    assign leftChannelPowerOn = powerEn[acc_pkg::PWR_LEFT_CH];
    assign rightOutDriverPowerOn = powerEn[acc_pkg::PWR_RIGHT_OUT];
    assign leftOutDriverPowerOn = powerEn[acc_pkg::PWR_LEFT_OUT];
    assign rightInAmpPowerOn = powerEn[acc_pkg::PWR_RIGHT_IN];
    assign leftInAmpPowerOn = powerEn[acc_pkg::PWR_LEFT_IN];
    assign leftInputGainCode = leftIn;
    assign rightInputGainCode = rightIn;
    assign leftPlaybackGainCode = leftPlay;
    assign rightPlaybackGainCode = rightPlay;
    assign leftInputCutOff = leftCut;
    assign rightInputCutOff = rightCut;
    assign leftPlaybackMute = leftMute;
    assign rightPlaybackMute = rightMute;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking

    sequence sPowerWrite;
        link.wrStb && link.wrAddr == acc_pkg::OFS_POWER;
    endsequence

    sequence sPlayWrite;
        link.wrStb && (link.wrAddr == acc_pkg::OFS_LEFT_PLAY || link.wrAddr == acc_pkg::OFS_RIGHT_PLAY);
    endsequence

    a_port_reset_high: assert property (
        @(posedge ref_clk) $past(srst) && !srst
        |-> auxPort == acc_pkg::AUX_RESET && auxiliaryPortPins == acc_pkg::AUX_RESET)
        else $error("port register not all ones after reset");

    a_power_reset_off: assert property (
        @(posedge ref_clk) $past(srst) && !srst |-> powerEn == acc_pkg::POWER_RESET && !monoAmpPowerOn)
        else $error("analog sections not powered down after reset");

    a_gain_reset_value: assert property (
        @(posedge ref_clk) $past(srst) && !srst
        |-> leftIn == acc_pkg::IN_GAIN_RESET && rightIn == acc_pkg::IN_GAIN_RESET
            && leftPlay == acc_pkg::PLAY_GAIN_RESET && rightPlay == acc_pkg::PLAY_GAIN_RESET)
        else $error("gain codes wrong after reset");

    a_select_follows_bit: assert property (
        @(posedge ref_clk) disable iff (srst)
        sfrWr && auxHit |=> link.selectN == $past(sfrWdata[acc_pkg::AUX_SEL_BIT]))
        else $error("select line does not follow port bit one");

    a_line_in_power: assert property (
        @(posedge ref_clk) disable iff (srst)
        sPowerWrite |=> leftInAmpPowerOn == $past(link.wrData[0])
            && rightInAmpPowerOn == $past(link.wrData[1]))
        else $error("line-in amplifier enables wrong");

    a_line_out_power: assert property (
        @(posedge ref_clk) disable iff (srst)
        sPowerWrite |=> leftOutDriverPowerOn == $past(link.wrData[2])
            && rightOutDriverPowerOn == $past(link.wrData[3]))
        else $error("line-out driver enables wrong");

    a_section_power: assert property (
        @(posedge ref_clk) disable iff (srst)
        sPowerWrite |=> {monoAmpPowerOn, auxAmpPowerOn, rightChannelPowerOn, leftChannelPowerOn}
            == $past(link.wrData[7:4]))
        else $error("amplifier or channel enables wrong");

    a_right_in_field: assert property (
        @(posedge ref_clk) disable iff (srst)
        link.wrStb && link.wrAddr == acc_pkg::OFS_RIGHT_IN
        |=> rightInputGainCode == $past(link.wrData[4:0]) && leftIn == $past(leftIn))
        else $error("right line-in gain not taken from bits 4:0");

    a_play_field: assert property (
        @(posedge ref_clk) disable iff (srst)
        sPlayWrite |=> (leftPlay == $past(link.wrData[5:0]) || rightPlay == $past(link.wrData[5:0]))
            && powerEn == $past(powerEn))
        else $error("playback gain not taken from bits 5:0");

    a_cut_flag: assert property (
        @(posedge ref_clk) disable iff (srst)
        leftInputCutOff == (leftInputGainCode == 5'h11) && rightInputCutOff == (rightInputGainCode == 5'h11))
        else $error("line-in cut-off flag disagrees with code");

    a_mute_flag: assert property (
        @(posedge ref_clk) disable iff (srst)
        leftPlaybackMute == (leftPlaybackGainCode == 6'h20) && rightPlaybackMute == (rightPlaybackGainCode == 6'h20))
        else $error("mute flag disagrees with playback code");

    a_read_answer: assert property (
        @(posedge ref_clk) disable iff (srst)
        sfrRd && auxHit |=> sfrRdata[3:0] == $past(auxPort[3:0]) && sfrRdata[7:5] == $past(auxPort[7:5])
            && sfrRdata[acc_pkg::AUX_DOUT_BIT] == $past(link.serialOut))
        else $error("port register read data wrong");

    a_left_in_field: assert property (
        @(posedge ref_clk) disable iff (srst)
        link.wrStb && link.wrAddr == acc_pkg::OFS_LEFT_IN
        |=> leftInputGainCode == $past(link.wrData[4:0]) && rightIn == $past(rightIn))
        else $error("left line-in gain not taken from bits 4:0");

    // read data must not linger, the host core samples it blindly
    a_read_idle_zero: assert property (
        @(posedge ref_clk) disable iff (srst)
        !(sfrRd && auxHit) |=> sfrRdata == 8'h00)
        else $error("read data not zero outside a read");

    a_power_holds: assert property (
        @(posedge ref_clk) disable iff (srst)
        !link.wrStb |=> powerEn == $past(powerEn))
        else $error("power enables changed without a link write");
endmodule : acc_ctrl_regs

// ===== test/acc_host_model.sv
/*
 * host core model: software that reaches the port register on the special
 * function bus and toggles its bits to run the converter's serial link.
 * assumes the bench calls its tasks; drives only at the falling clock edge.
 */
`timescale 1ns/1ps
module acc_host_model (
    input wire logic ref_clk,
    output logic [7:0] sfrAddr,
    output logic sfrWr,
    output logic sfrRd,
    output logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata
);
    logic [7:0] portShadow;

    initial
    begin
        sfrAddr = 8'h00;
        sfrWr = 1'b0;
        sfrRd = 1'b0;
        sfrWdata = 8'h00;
        portShadow = acc_pkg::AUX_RESET;
    end

    ////////////////////////////////////////////////////////////////////////////
    // released bus lines show the inverse so stale values never match
    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge ref_clk);
        sfrAddr = addr;
        sfrWdata = data;
        sfrWr = 1'b1;
        @(negedge ref_clk);
        sfrWr = 1'b0;
        sfrAddr = ~addr;
        sfrWdata = ~data;
    endtask : sfr_write

    task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
        @(negedge ref_clk);
        sfrAddr = addr;
        sfrRd = 1'b1;
        @(negedge ref_clk);
        data = sfrRdata;
        sfrRd = 1'b0;
        sfrAddr = ~addr;
    endtask : sfr_read

    ////////////////////////////////////////////////////////////////////////////
    // each level is held four cycles, the slave samples on its own clock
    task automatic set_pins(input logic sel, input logic sclk, input logic din);
        portShadow[acc_pkg::AUX_SEL_BIT] = sel;
        portShadow[acc_pkg::AUX_CLK_BIT] = sclk;
        portShadow[acc_pkg::AUX_DIN_BIT] = din;
        sfr_write(acc_pkg::AUX_ADDR, portShadow);
        repeat (2) @(negedge ref_clk);
    endtask : set_pins

    // one frame: command byte then data byte, msb first; sel high makes a dry run
    task automatic frame(input logic sel, input logic rd, input logic [6:0] ofs,
        input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] bits;
        logic [7:0] pinv;
        bits = {rd, ofs, wdata};
        rdata = 8'h00;
        set_pins(sel, 1'b1, 1'b1);
        for (int i = 0; i < 16; i++)
        begin
            set_pins(sel, 1'b0, bits[15 - i]);
            if (i >= 8)
            begin
                sfr_read(acc_pkg::AUX_ADDR, pinv);
                rdata[15 - i] = pinv[acc_pkg::AUX_DOUT_BIT];
            end
            set_pins(sel, 1'b1, bits[15 - i]);
        end
        set_pins(1'b1, 1'b1, 1'b1);
    endtask : frame
endmodule : acc_host_model

// ===== test/test_audio_converter_control_regs.sv
/*
 * self-checking bench of the audio converter control block: port register,
 * power enables and gain selectors reached through the software serial link.
 * assumes the host model in acc_host_model.sv and the design under hw/.
 */
`timescale 1ns/1ps
module test_audio_converter_control_regs;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] sfrAddr;
    logic sfrWr;
    logic sfrRd;
    logic [7:0] sfrWdata;
    logic [7:0] sfrRdata;
    logic [7:0] auxiliaryPortPins;
    logic converterSerialOut;
    wire logic [7:0] powerVec;
    logic [4:0] leftInputGainCode;
    logic [4:0] rightInputGainCode;
    logic [5:0] leftPlaybackGainCode;
    logic [5:0] rightPlaybackGainCode;
    logic leftInputCutOff;
    logic rightInputCutOff;
    logic leftPlaybackMute;
    logic rightPlaybackMute;
    int errors = 0;
    int comparisons = 0;
    logic [7:0] rd;

    always #10 ref_clk = ~ref_clk;

    acc_ctrl_regs u_dut (.ref_clk(ref_clk), .srst(srst), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
        .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .auxiliaryPortPins(auxiliaryPortPins),
        .converterSerialOut(converterSerialOut), .monoAmpPowerOn(powerVec[7]), .auxAmpPowerOn(powerVec[6]),
        .rightChannelPowerOn(powerVec[5]), .leftChannelPowerOn(powerVec[4]),
        .rightOutDriverPowerOn(powerVec[3]), .leftOutDriverPowerOn(powerVec[2]),
        .rightInAmpPowerOn(powerVec[1]), .leftInAmpPowerOn(powerVec[0]),
        .leftInputGainCode(leftInputGainCode), .rightInputGainCode(rightInputGainCode),
        .leftPlaybackGainCode(leftPlaybackGainCode), .rightPlaybackGainCode(rightPlaybackGainCode),
        .leftInputCutOff(leftInputCutOff), .rightInputCutOff(rightInputCutOff),
        .leftPlaybackMute(leftPlaybackMute), .rightPlaybackMute(rightPlaybackMute));

    acc_host_model u_host (.ref_clk(ref_clk), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
        .sfrWdata(sfrWdata), .sfrRdata(sfrRdata));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic stop_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    // reset held two cycles, then the reset state at every pin and the port read
    task automatic reset_check;
        srst = 1'b1;
        repeat (2) @(negedge ref_clk);
        srst = 1'b0;
        check("portPins", acc_pkg::AUX_RESET, auxiliaryPortPins);
        check("serialIdle", 8'h01, {7'h00, converterSerialOut});
        u_host.sfr_read(acc_pkg::AUX_ADDR, rd);
        check("portRead", 8'hff, rd);
        check("power", acc_pkg::POWER_RESET, powerVec);
        check("leftIn", 8'h05, {3'b000, leftInputGainCode});
        check("rightIn", 8'h05, {3'b000, rightInputGainCode});
        check("leftPlay", 8'h08, {2'b00, leftPlaybackGainCode});
        check("rightPlay", 8'h08, {2'b00, rightPlaybackGainCode});
        check("flags", 8'h00, {4'h0, leftInputCutOff, rightInputCutOff, leftPlaybackMute, rightPlaybackMute});
    endtask : reset_check

    // flag in bit 7, code below it, per gain register offset
    function automatic logic [7:0] seen(input logic [6:0] ofs);
        case (ofs)
            acc_pkg::OFS_LEFT_IN: seen = {leftInputCutOff, 2'b00, leftInputGainCode};
            acc_pkg::OFS_RIGHT_IN: seen = {rightInputCutOff, 2'b00, rightInputGainCode};
            acc_pkg::OFS_LEFT_PLAY: seen = {leftPlaybackMute, 1'b0, leftPlaybackGainCode};
            default: seen = {rightPlaybackMute, 1'b0, rightPlaybackGainCode};
        endcase
    endfunction : seen

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        stop_test();
    end

    initial
    begin
        logic [7:0] resetVals [5];
        logic [6:0] gainOfs [8];
        logic [7:0] gainData [8];
        logic [7:0] code;
        logic [7:0] mask;
        logic flag;
        resetVals = '{8'h00, 8'h05, 8'h05, 8'h08, 8'h08};
        gainOfs = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h02, 7'h04, 7'h01, 7'h03};
        gainData = '{8'h11, 8'hff, 8'h20, 8'hff, 8'h11, 8'h20, 8'h00, 8'h3f};
        // reset state at the pins and through both paths
        reset_check();
        for (int i = 0; i < 5; i++)
        begin
            u_host.frame(1'b0, 1'b1, 7'(i), 8'h00, rd);
            check("resetRead", resetVals[i], rd);
        end

        // other special function addresses leave the port alone
        u_host.sfr_write(8'h91, 8'h00);
        check("portPins", 8'hff, auxiliaryPortPins);
        u_host.sfr_read(8'h91, rd);
        check("otherRead", 8'h00, rd);

        // a whole write frame clocked while deselected must do nothing
        u_host.frame(1'b1, 1'b0, acc_pkg::OFS_POWER, 8'hff, rd);
        check("powerDeselected", 8'h00, powerVec);

        // walking one through the power enables, read back each time
        for (int i = 0; i < 8; i++)
        begin
            u_host.frame(1'b0, 1'b0, acc_pkg::OFS_POWER, 8'h01 << i, rd);
            check("power", 8'h01 << i, powerVec);
            u_host.frame(1'b0, 1'b1, acc_pkg::OFS_POWER, 8'h00, rd);
            check("powerRead", 8'h01 << i, rd);
        end

        // gain selectors: field width, unused bits, cut-off and mute codes
        for (int i = 0; i < 8; i++)
        begin
            mask = (gainOfs[i] < 7'h03) ? 8'h1f : 8'h3f;
            code = gainData[i] & mask;
            flag = (gainOfs[i] < 7'h03) ? (code == 8'h11) : (code == 8'h20);
            u_host.frame(1'b0, 1'b0, gainOfs[i], gainData[i], rd);
            check("gainPins", {flag, code[6:0]}, seen(gainOfs[i]));
            u_host.frame(1'b0, 1'b1, gainOfs[i], 8'h00, rd);
            check("gainRead", code, rd);
        end

        // reset in mid-run brings every register back
        reset_check();
        u_host.frame(1'b0, 1'b1, acc_pkg::OFS_LEFT_PLAY, 8'h00, rd);
        check("resetReadAgain", 8'h08, rd);
        check("portIdle", 8'hff, auxiliaryPortPins);
        check("serialEnd", 8'h01, {7'h00, converterSerialOut});
        stop_test();
    end
endmodule : test_audio_converter_control_regs
